// file: design/slg_gain_decode.sv
// decodes one mantissa/exponent pair into a 6-bit mantissa and a right shift
`timescale 1ns/1ps
module slg_gain_decode
	import slg_pkg::*;
(
	input  wire logic [3:0] mant,      // 4 fractional mantissa bits
	input  wire logic [4:0] expo,      // 5-bit exponent field
	output logic      [5:0] mant_full, // 01.ffff as unsigned value
	output logic      [5:0] shift      // right shift from nco msb
);
	// implied binary 01 ahead of the fraction
	assign mant_full = {2'b01, mant};
	// all ones gives 2^-1, all zeros 2^-32
	assign shift = slg_exp_shift(expo);
endmodule

// file: design/slg_pkg.sv
// constants for the symbol loop gain and lag-initialization block
package slg_pkg;
	// destination addresses on the 8-bit control interface
	localparam logic [7:0] SLG_ADDR_GAIN_ACQ = 8'h11;
	localparam logic [7:0] SLG_ADDR_GAIN_TRK = 8'h12;
	localparam logic [7:0] SLG_ADDR_LAG_INIT = 8'h13;
	localparam logic [7:0] SLG_ADDR_STATUS   = 8'h00;
	// gain register field positions
	localparam int SLG_LEAD_MANT_HI = 17;
	localparam int SLG_LEAD_MANT_LO = 14;
	localparam int SLG_LEAD_EXP_HI  = 13;
	localparam int SLG_LEAD_EXP_LO  = 9;
	localparam int SLG_LAG_MANT_HI  = 8;
	localparam int SLG_LAG_MANT_LO  = 5;
	localparam int SLG_LAG_EXP_HI   = 4;
	localparam int SLG_LAG_EXP_LO   = 0;
	localparam int SLG_GAIN_USED_HI = 17;
	// widths
	localparam int SLG_ACC_W   = 40;
	localparam int SLG_HOLD_W  = 32;
	localparam int SLG_FRAC_W  = 8;
	localparam int SLG_SHIFT_W = 6;
	localparam int SLG_EXP_BIAS = 32;
	// reset values
	localparam logic [31:0] SLG_GAIN_RST = 32'h0000_0000;
	// status bit position
	localparam int SLG_STAT_LOADED = 0;
	localparam int SLG_STAT_PEND   = 1;
	localparam int SLG_STAT_TRACK  = 2;
	// init state machine
	typedef enum logic [1:0] {
		SLG_IDLE = 2'b00,
		SLG_PEND = 2'b01,
		SLG_DONE = 2'b11
	} slg_init_e;
	// shift right applied for an exponent field: 32 - e
	function automatic logic [5:0] slg_exp_shift(input logic [4:0] e);
		slg_exp_shift = 6'(SLG_EXP_BIAS) - {1'b0, e};
	endfunction
endpackage

// file: design/slg_top.sv
// symbol loop gain registers and lag accumulator initialization
// Contract
// - lead exponent bits 13:9 scale 2^-(32-E)
// - exponent 11111 gives 2^-1, 00000 2^-32
// - lag mantissa bits 8:5 like lead
// - lag exponent bits 4:0 same formula
// - tracking register repeats acquisition field layout
// - init write loads accumulator at next compute
// - holding words to upper 32, low 8 cleared
// - status bit reports lag load complete
// - mantissa is implied 01 plus four fraction
// - accumulator 40 bits, limit clamps, low zeroed
`timescale 1ns/1ps
module slg_top
	import slg_pkg::*;
(
	input  wire logic        ref_clk,       // device clock, 40 MHz
	input  wire logic        rst_n,         // synchronous reset, active low
	input  wire logic [7:0]  addr,          // destination / read address
	input  wire logic        wr_strobe,     // one-cycle write of holding words
	input  wire logic        rd_strobe,     // one-cycle status read
	input  wire logic [31:0] hold_data,     // four holding registers, joined
	output logic      [7:0]  rd_data,       // read data, registered
	input  wire logic        compute_start, // loop filter compute cycle start
	input  wire logic        track_mode,    // 1 = track, 0 = acquire
	input  wire logic        acc_update,    // datapath writes accumulator
	input  wire logic [39:0] acc_next,      // datapath next accumulator
	input  wire logic        limit_hit,     // datapath saw a limit crossing
	input  wire logic [31:0] limit_value,   // limit the datapath clamped to
	output logic      [39:0] lag_acc,       // lag accumulator
	output logic      [5:0]  lead_mant,     // selected lead mantissa 01.ffff
	output logic      [5:0]  lead_shift,    // selected lead right shift
	output logic      [5:0]  lag_mant,      // selected lag mantissa 01.ffff
	output logic      [5:0]  lag_shift,     // selected lag right shift
	output logic             init_busy      // load scheduled, not yet done
);
	import slg_pkg::*;

	// only bits 17:0 of either gain word carry meaning; the rest is dropped
	logic [17:0] gain_acq_q;
	logic [17:0] gain_trk_q;
	logic [17:0] gain_sel;
	logic        track_q;
	slg_init_e   init_q;
	logic        loaded_q;
	logic        wr_init;
	logic        load_now;
	logic [5:0]  lead_mant_d;
	logic [5:0]  lead_shift_d;
	logic [5:0]  lag_mant_d;
	logic [5:0]  lag_shift_d;

	// true when the address equals the given destination address; callers gate it with wr_strobe
	function automatic logic hits(input logic [7:0] a, input logic [7:0] dest);
		hits = (a == dest);
	endfunction

	// an init request is a write to the lag-initialization address; no data is taken
	// from the strobe itself, the holding words are read only when the load fires
	assign wr_init = wr_strobe && hits(addr, SLG_ADDR_LAG_INIT);

	// the load fires on the first compute start after the request was seen;
	// sharing one term keeps the accumulator and the done flag in step
	assign load_now = (init_q == SLG_PEND) && compute_start;

	// gain registers keep only the used bits; reserved and unused are dropped
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			gain_acq_q <= SLG_GAIN_RST[SLG_GAIN_USED_HI:0];
			gain_trk_q <= SLG_GAIN_RST[SLG_GAIN_USED_HI:0];
		end else if (wr_strobe) begin
			if (hits(addr, SLG_ADDR_GAIN_ACQ)) begin
				gain_acq_q <= hold_data[SLG_GAIN_USED_HI:0];
			end
			if (hits(addr, SLG_ADDR_GAIN_TRK)) begin
				gain_trk_q <= hold_data[SLG_GAIN_USED_HI:0];
			end
		end
	end

	// mode is sampled at compute start so the selected gain set switches only between cycles;
	// a mid-cycle mode flip would otherwise mix lead and lag from two sets
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			track_q <= 1'b0;
		end else if (compute_start) begin
			track_q <= track_mode;
		end
	end

	// pick acquisition or tracking set
	assign gain_sel = track_q ? gain_trk_q : gain_acq_q;

	// both sets share one layout, so one decoder pair serves either
	slg_gain_decode u_lead (
		.mant      (gain_sel[SLG_LEAD_MANT_HI:SLG_LEAD_MANT_LO]),
		.expo      (gain_sel[SLG_LEAD_EXP_HI:SLG_LEAD_EXP_LO]),
		.mant_full (lead_mant_d),
		.shift     (lead_shift_d)
	);
	slg_gain_decode u_lag (
		.mant      (gain_sel[SLG_LAG_MANT_HI:SLG_LAG_MANT_LO]),
		.expo      (gain_sel[SLG_LAG_EXP_HI:SLG_LAG_EXP_LO]),
		.mant_full (lag_mant_d),
		.shift     (lag_shift_d)
	);

	// registered gain outputs for the datapath; a gain write reaches them two
	// edges later, once through the gain register and once through these flops
	// reset shows gain word zero: mantissa 01.0000, shift 32 (smallest gain)
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lead_mant  <= 6'h10;
			lead_shift <= 6'h20;
			lag_mant   <= 6'h10;
			lag_shift  <= 6'h20;
		end else begin
			lead_mant  <= lead_mant_d;
			lead_shift <= lead_shift_d;
			lag_mant   <= lag_mant_d;
			lag_shift  <= lag_shift_d;
		end
	end

	// init sequencer: a write schedules, the next compute start performs it
	// a second request while pending simply stays pending; a request that
	// meets the completing compute start is served by that same load
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			init_q <= SLG_IDLE;
		end else begin
			case (init_q)
				SLG_IDLE: begin
					if (wr_init) begin
						init_q <= SLG_PEND;
					end
				end
				SLG_PEND: begin
					if (compute_start) begin
						init_q <= SLG_DONE;
					end
				end
				SLG_DONE: begin
					init_q <= wr_init ? SLG_PEND : SLG_IDLE;
				end
				default: begin
					init_q <= SLG_IDLE;
				end
			endcase
		end
	end

	// the accumulator samples the holding words only at compute start; host keeps them stable
	// priority: init load, then limit clamp, then the normal datapath update;
	// a clamp or init always leaves the 8 fraction bits at zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			lag_acc <= '0;
		end else if (load_now) begin
			lag_acc <= {hold_data, {SLG_FRAC_W{1'b0}}};
		end else if (limit_hit) begin
			lag_acc <= {limit_value, {SLG_FRAC_W{1'b0}}};
		end else if (acc_update) begin
			lag_acc <= acc_next;
		end
	end

	// sticky load-complete flag; a new request clears it, completion wins
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			loaded_q <= 1'b0;
		end else if (load_now) begin
			loaded_q <= 1'b1;
		end else if (wr_init) begin
			loaded_q <= 1'b0;
		end
	end

	// pending indication straight from the sequencer state
	assign init_busy = (init_q == SLG_PEND);

	// status read: loaded, pending, track mode; other addresses read zero
	// and rd_data holds its value between reads
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
		end else if (rd_strobe) begin
			case (addr)
				SLG_ADDR_STATUS: begin
					rd_data <= {5'b0_0000, track_q, init_busy, loaded_q};
				end
				default: begin
					rd_data <= 8'h00;
				end
			endcase
		end
	end
endmodule

// file: verification/slg_host.sv
// host model on the control interface
`timescale 1ns/1ps
module slg_host(
	input  wire logic        ref_clk,   // device clock
	output logic      [7:0]  addr,      // destination address
	output logic             wr_strobe, // write strobe
	output logic             rd_strobe, // read strobe
	output logic      [31:0] hold_data  // holding registers
);
	initial {addr, wr_strobe, rd_strobe, hold_data} = '0;
	// one-cycle write; the holding words then stay put
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		hold_data <= d;
		wr_strobe <= 1;
		@(posedge ref_clk);
		wr_strobe <= 0;
	endtask
	// one-cycle read
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_strobe <= 1;
		@(posedge ref_clk);
		rd_strobe <= 0;
	endtask
endmodule

// file: verification/slg_top_chk.sv
// assertions on the gain and lag-init ports
`timescale 1ns/1ps
module slg_top_chk(
	input wire logic ref_clk, rst_n, wr_strobe, rd_strobe, compute_start, track_mode,
	input wire logic limit_hit, init_busy,
	input wire logic [7:0] addr, rd_data,
	input wire logic [31:0] hold_data, limit_value,
	input wire logic [39:0] lag_acc,
	input wire logic [5:0] lead_mant, lead_shift, lag_mant, lag_shift
);
	logic mode_q;
	logic [31:0] hd_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// mode as latched at compute start, and the last written word
	always_ff @(posedge ref_clk) if (!rst_n) mode_q <= 0; else if (compute_start) mode_q <= track_mode;
	always_ff @(posedge ref_clk) if (wr_strobe) hd_q <= hold_data;
	sequence gw(a, m);
		wr_strobe && addr == a && mode_q == m && !compute_start ##1 !compute_start && !wr_strobe;
	endsequence
	// gain register updates one edge after the write, the output flops one edge later
	acq_gain_a: assert property (gw(8'h11, 0) |-> ##2 lead_mant == {2'b01, hd_q[17:14]}
		&& lead_shift == 6'd32 - hd_q[13:9]) else $error("acq lead gain wrong");
	trk_gain_a: assert property (gw(8'h12, 1) |-> ##2 lag_mant == {2'b01, hd_q[8:5]}
		&& lag_shift == 6'd32 - hd_q[4:0]) else $error("track lag gain wrong");
	init_load_a: assert property (init_busy && compute_start |=>
		lag_acc == {$past(hold_data), 8'h00}) else $error("lag init wrong");
	busy_set_a: assert property (wr_strobe && addr == 8'h13 && !compute_start |=> init_busy)
		else $error("init not pending");
	busy_clear_a: assert property (init_busy && compute_start && !wr_strobe |=> !init_busy)
		else $error("init still pending");
	clamp_val_a: assert property (limit_hit && !(init_busy && compute_start) |=>
		lag_acc == {$past(limit_value), 8'h00}) else $error("clamp wrong");
	mant_form_a: assert property (lead_mant[5:4] == 2'b01 && lag_mant[5:4] == 2'b01)
		else $error("mantissa lead bits wrong");
	unmapped_read_a: assert property (rd_strobe && addr == 8'h55 |=> rd_data == 8'h00)
		else $error("unmapped read not zero");
	cover property (init_busy && compute_start);
	cover property (limit_hit);
	cover property (gw(8'h12, 1));
endmodule
bind slg_top slg_top_chk i_chk(.ref_clk, .rst_n, .wr_strobe, .rd_strobe, .compute_start,
	.track_mode, .limit_hit, .init_busy, .addr, .rd_data, .hold_data, .limit_value, .lag_acc,
	.lead_mant, .lead_shift, .lag_mant, .lag_shift);

// file: verification/slg_top_test.sv
// self-checking bench for the symbol loop gain block
`timescale 1ns/1ps
module slg_top_test;
	import slg_pkg::*;
	logic ref_clk = 0, rst_n = 0, compute_start = 0, track_mode = 0, limit_hit = 0;
	logic acc_update = 0;
	logic [39:0] acc_next = 0;
	logic [31:0] limit_value = 0, hold_data;
	logic [39:0] lag_acc;
	logic [7:0] addr, rd_data;
	logic wr_strobe, rd_strobe, init_busy;
	logic [5:0] lead_mant, lead_shift, lag_mant, lag_shift;
	int num_errors = 0, checks = 0, cyc = 0;
	// gain words, bits 23:18 zero, unused top byte set
	localparam logic [31:0] W0 = 32'ha502_7ec0, W1 = 32'h5a01_8136;
	initial forever #12.5 ref_clk = ~ref_clk;
	slg_host i_host(.ref_clk, .addr, .wr_strobe, .rd_strobe, .hold_data);
	slg_top i_dut(.ref_clk, .rst_n, .addr, .wr_strobe, .rd_strobe, .hold_data, .rd_data,
		.compute_start, .track_mode, .acc_update, .acc_next, .limit_hit,
		.limit_value, .lag_acc, .lead_mant, .lead_shift, .lag_mant, .lag_shift, .init_busy);
	task automatic chk(input string n, input logic [39:0] e, input logic [39:0] s);
		checks++;
		if (s !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// gain outputs against the fields of word w
	task automatic gk(input logic [31:0] w);
		@(posedge ref_clk);
		#1;
		chk("lead_mant", {2'b01, w[17:14]}, lead_mant);
		chk("lead_shift", 6'd32 - w[13:9], lead_shift);
		chk("lag_mant", {2'b01, w[8:5]}, lag_mant);
		chk("lag_shift", 6'd32 - w[4:0], lag_shift);
	endtask
	task automatic cs(input logic t);
		@(posedge ref_clk);
		compute_start <= 1;
		track_mode <= t;
		@(posedge ref_clk);
		compute_start <= 0;
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 1000) begin
			num_errors++;
			stop_test;
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		gk(32'h0);
		chk("lag_acc", 0, lag_acc);
		@(posedge ref_clk) rst_n <= 1;
		$display("reset test done");
		i_host.wr(8'h11, W0);
		gk(W0);
		i_host.wr(8'h11, W1);
		gk(W1);
		i_host.wr(8'h12, W0);
		gk(W1);
		cs(1);
		gk(W0);
		i_host.wr(8'h12, W1);
		gk(W1);
		i_host.wr(8'h11, W0);
		gk(W1);
		cs(0);
		gk(W0);
		$display("gain test done");
		i_host.wr(8'h13, 32'h89ab_cdef);
		#1 chk("init_busy", 1, init_busy);
		i_host.rd(8'h00);
		#1 chk("status", 8'h02, rd_data);
		cs(0);
		#1 chk("lag_acc", 40'h89_abcd_ef00, lag_acc);
		i_host.rd(8'h00);
		#1 chk("status", 8'h01, rd_data);
		i_host.rd(8'h55);
		#1 chk("unmapped", 0, rd_data);
		@(posedge ref_clk) limit_value <= 32'h8000_0001;
		limit_hit <= 1;
		@(posedge ref_clk) limit_hit <= 0;
		#1 chk("clamp", 40'h80_0000_0100, lag_acc);
		@(posedge ref_clk) acc_next <= 40'h12_3456_7890;
		acc_update <= 1;
		@(posedge ref_clk) acc_update <= 0;
		#1 chk("acc_update", 40'h12_3456_7890, lag_acc);
		cs(1);
		i_host.rd(8'h00);
		#1 chk("status_trk", 8'h05, rd_data);
		$display("init test done");
		stop_test;
	end
endmodule
